// ---- core/vic_ctrl.sv ----
// Vectored interrupt controller with Wishbone register access
`timescale 1ns/10ps
module vic_ctrl
    import vic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic watchdog_overflow_irq,
    input wire logic pin_edge_irq_0,
    input wire logic pin_edge_irq_1,
    input wire logic pin_edge_irq_2,
    input wire logic pin_edge_irq_3,
    input wire logic serial_rx_done_irq,
    input wire logic serial_sync_xfer_done_irq,
    input wire logic serial_tx_done_irq,
    input wire logic watch_interval_irq,
    input wire logic timer16_match_irq,
    input wire logic timer8a_match_irq,
    input wire logic timer8b_match_irq,
    input wire logic adc_done_irq,
    input wire logic watch_timer_irq,
    input wire logic key_return_irq,
    input wire logic cpu_ack,
    output logic service_req,
    output logic service_nmi,
    output logic [15:0] service_vector,
    output logic global_irq_enable,
    output logic standby_release
);

    // Lowest set index of a request vector
    function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[3:0];
            end
        end
        return idx;
    endfunction

    // Low register byte: transmit in bit 7, unused bit 6 reads as fill
    function automatic logic [7:0] lo_byte(input logic [NUM_SRC-1:0] v,
                                           input logic fill);
        return {v[PRI_SER_TX], fill, v[5:0]};
    endfunction

    // High register byte: unused bit 7 reads as fill
    function automatic logic [7:0] hi_byte(input logic [NUM_SRC-1:0] v,
                                           input logic fill);
        return {fill, v[13:7]};
    endfunction

    // Register bytes back into priority order; unused bits are dropped
    function automatic logic [NUM_SRC-1:0] to_prio(input logic [7:0] lo,
                                                   input logic [7:0] hi);
        return {hi[6:0], lo[LO_TX_BIT], lo[5:0]};
    endfunction

    logic [NUM_SRC-1:0] pending_ff;
    logic [NUM_SRC-1:0] nxt_pending;
    logic [NUM_SRC-1:0] disable_ff;
    logic [NUM_SRC-1:0] nxt_disable;
    logic nmi_pend_ff;
    logic nxt_nmi_pend;
    logic ie_ff;
    logic nxt_ie;
    logic [1:0] wdm_ff;
    logic [1:0] nxt_wdm;
    vic_state_e state_ff;
    vic_state_e nxt_state;
    logic [4:0] wait_ff;
    logic [4:0] nxt_wait;
    logic sel_nmi_ff;
    logic [3:0] sel_idx_ff;
    logic [3:0] nxt_sel_idx;
    logic nxt_sel_nmi;
    logic [15:0] vector_ff;
    logic [15:0] nxt_vector;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i;
    // Writes land in the ack cycle only, so each access writes once
    wire bus_wr = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
    wire hit_pend_lo = (wb_adr_i == ADDR_PEND_LO);
    wire hit_pend_hi = (wb_adr_i == ADDR_PEND_HI);
    wire hit_dis_lo = (wb_adr_i == ADDR_DIS_LO);
    wire hit_dis_hi = (wb_adr_i == ADDR_DIS_HI);
    wire hit_ctrl = (wb_adr_i == ADDR_CTRL);
    wire hit_stat = (wb_adr_i == ADDR_STAT);
    wire wr_pend_lo = bus_wr & hit_pend_lo;
    wire wr_pend_hi = bus_wr & hit_pend_hi;
    wire wr_dis_lo = bus_wr & hit_dis_lo;
    wire wr_dis_hi = bus_wr & hit_dis_hi;
    wire wr_ctrl = bus_wr & hit_ctrl;
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire wd_interval = (wdm_ff == WDM_INTERVAL);
    wire wd_mode1 = (wdm_ff == WDM_MODE1);

    // Source events in priority order
    wire [NUM_SRC-1:0] src_evt;
    assign src_evt[PRI_WDT] = watchdog_overflow_irq & wd_interval;
    assign src_evt[PRI_PIN0] = pin_edge_irq_0;
    assign src_evt[PRI_PIN1] = pin_edge_irq_1;
    assign src_evt[PRI_PIN2] = pin_edge_irq_2;
    assign src_evt[PRI_PIN3] = pin_edge_irq_3;
    assign src_evt[PRI_SER_RX] = serial_rx_done_irq
                               | serial_sync_xfer_done_irq;
    assign src_evt[PRI_SER_TX] = serial_tx_done_irq;
    assign src_evt[PRI_WTI] = watch_interval_irq;
    assign src_evt[PRI_TM16] = timer16_match_irq;
    assign src_evt[PRI_TM8A] = timer8a_match_irq;
    assign src_evt[PRI_TM8B] = timer8b_match_irq;
    assign src_evt[PRI_ADC] = adc_done_irq;
    assign src_evt[PRI_WT] = watch_timer_irq;
    assign src_evt[PRI_KEY] = key_return_irq;

    // Map register bytes onto priority order; unused bits are not stored
    wire [NUM_SRC-1:0] pend_wr_val;
    wire [NUM_SRC-1:0] pend_wr_en;
    wire [NUM_SRC-1:0] dis_wr_val;
    wire [NUM_SRC-1:0] dis_wr_en;
    assign pend_wr_val = to_prio(wbyte, wbyte);
    assign dis_wr_val = to_prio(wbyte, wbyte);
    // Watchdog flag is frozen outside interval mode
    assign pend_wr_en = {{7{wr_pend_hi}}, {7{wr_pend_lo}}}
                      & {{(NUM_SRC-1){1'b1}}, wd_interval};
    assign dis_wr_en = {{7{wr_dis_hi}}, {7{wr_dis_lo}}};

    // Arbitration
    wire [NUM_SRC-1:0] unmasked = pending_ff & ~disable_ff;
    wire any_unmasked = |unmasked;
    wire mask_ok = any_unmasked & ie_ff;
    wire eligible = nmi_pend_ff | mask_ok;
    wire [3:0] win_idx = first_set(unmasked);

    // Acknowledge clears the latched source
    wire take = (state_ff == VIC_REQ) & cpu_ack;
    wire [NUM_SRC-1:0] ack_clr;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_flag
            assign ack_clr[g] = take & ~sel_nmi_ff & (sel_idx_ff == g);
            // Software value, then ack clear, then source set on top
            assign nxt_pending[g] = src_evt[g]
                | (~ack_clr[g] & (pend_wr_en[g] ? pend_wr_val[g]
                                                : pending_ff[g]));
            assign nxt_disable[g] = dis_wr_en[g] ? dis_wr_val[g]
                                                 : disable_ff[g];
        end
    endgenerate

    assign nxt_nmi_pend = (watchdog_overflow_irq & wd_mode1)
                        | (nmi_pend_ff & ~(take & sel_nmi_ff));
    // Hardware clear on acknowledge beats a software write
    assign nxt_ie = take ? 1'b0
                  : (wr_ctrl ? wbyte[CTRL_IE_BIT] : ie_ff);
    assign nxt_wdm = wr_ctrl ? wbyte[CTRL_WDM_LSB +: 2] : wdm_ff;

    // Sequencer: hold the request for the minimum latency first
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_sel_nmi = sel_nmi_ff;
        nxt_sel_idx = sel_idx_ff;
        nxt_vector = vector_ff;
        unique case (state_ff)
            VIC_IDLE: begin
                nxt_wait = 5'h01;
                if (eligible) begin
                    nxt_state = VIC_WAIT;
                end
            end
            VIC_WAIT: begin
                // Conditions withdrawn: fall back and stay pending
                if (!eligible) begin
                    nxt_state = VIC_IDLE;
                end else if (wait_ff >= SERVICE_MIN_CYC - 5'h01) begin
                    // Latch the winner so the vector stays put for the CPU
                    nxt_state = VIC_REQ;
                    nxt_sel_nmi = nmi_pend_ff;
                    nxt_sel_idx = win_idx;
                    nxt_vector = nmi_pend_ff ? VEC_NMI
                                             : VEC_TABLE[win_idx];
                end else begin
                    nxt_wait = wait_ff + 5'h01;
                end
            end
            VIC_REQ: begin
                if (wait_ff != SERVICE_MAX_CYC) begin
                    nxt_wait = wait_ff + 5'h01;
                end
                if (cpu_ack) begin
                    nxt_state = VIC_IDLE;
                end
            end
        endcase
    end

    // Register read mux
    wire [7:0] pend_lo_rd = lo_byte({pending_ff[NUM_SRC-1:1],
                                     pending_ff[PRI_WDT] & wd_interval},
                                    1'b0);
    wire [7:0] pend_hi_rd = hi_byte(pending_ff, 1'b0);
    // Watchdog mask reads its stored bit in every mode
    wire [7:0] dis_lo_rd = lo_byte(disable_ff, 1'b1);
    wire [7:0] dis_hi_rd = hi_byte(disable_ff, 1'b1);
    wire [31:0] ctrl_rd = {29'h0, wdm_ff, ie_ff};
    wire [31:0] stat_rd = {13'h0, standby_release, nmi_pend_ff,
                           service_req, vector_ff};
    wire [31:0] rd_mux =
        hit_pend_lo ? {24'h0, pend_lo_rd} :
        hit_pend_hi ? {24'h0, pend_hi_rd} :
        hit_dis_lo ? {24'h0, dis_lo_rd} :
        hit_dis_hi ? {24'h0, dis_hi_rd} :
        hit_ctrl ? ctrl_rd :
        hit_stat ? stat_rd : 32'h0;

    // A request held through the ack is answered only every other cycle
    assign nxt_ack = bus_req & ~ack_ff;
    // Read data is captured once per access and held for the master
    assign nxt_rdata = nxt_ack ? rd_mux : rdata_ff;

    // Bus answer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Flag and control registers; masks come up set so nothing fires
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending_ff <= PEND_RST_VEC;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            disable_ff <= DIS_RST_VEC;
        end else begin
            disable_ff <= nxt_disable;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pend_ff <= 1'b0;
        end else begin
            nmi_pend_ff <= nxt_nmi_pend;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ie_ff <= 1'b0;
        end else begin
            ie_ff <= nxt_ie;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdm_ff <= WDM_INTERVAL;
        end else begin
            wdm_ff <= nxt_wdm;
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= VIC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 5'h0;
        end else begin
            wait_ff <= nxt_wait;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_nmi_ff <= 1'b0;
        end else begin
            sel_nmi_ff <= nxt_sel_nmi;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_idx_ff <= 4'h0;
        end else begin
            sel_idx_ff <= nxt_sel_idx;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vector_ff <= 16'h0;
        end else begin
            vector_ff <= nxt_vector;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign service_req = (state_ff == VIC_REQ);
    assign service_nmi = sel_nmi_ff;
    assign service_vector = vector_ff;
    assign global_irq_enable = ie_ff;
    // Wakes a halted core even with the global enable off
    assign standby_release = nmi_pend_ff | any_unmasked;

endmodule

// ---- core/vic_pkg.sv ----
// Constants, register map and vector table of the interrupt controller
package vic_pkg;

    // Number of maskable sources, indexed by fixed priority (0 highest)
    localparam int NUM_SRC = 14;

    // Priority slots
    localparam int PRI_WDT = 0;
    localparam int PRI_PIN0 = 1;
    localparam int PRI_PIN1 = 2;
    localparam int PRI_PIN2 = 3;
    localparam int PRI_PIN3 = 4;
    localparam int PRI_SER_RX = 5;
    localparam int PRI_SER_TX = 6;
    localparam int PRI_WTI = 7;
    localparam int PRI_TM16 = 8;
    localparam int PRI_TM8A = 9;
    localparam int PRI_TM8B = 10;
    localparam int PRI_ADC = 11;
    localparam int PRI_WT = 12;
    localparam int PRI_KEY = 13;

    // Vector addresses
    localparam logic [15:0] VEC_NMI = 16'h0004;
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
        16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
        16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
        16'h001e, 16'h0020
    };

    // Wishbone byte addresses
    localparam logic [7:0] ADDR_PEND_LO = 8'h00;
    localparam logic [7:0] ADDR_PEND_HI = 8'h04;
    localparam logic [7:0] ADDR_DIS_LO = 8'h08;
    localparam logic [7:0] ADDR_DIS_HI = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // Reset values
    localparam logic [7:0] PEND_RST = 8'h00;
    localparam logic [7:0] DIS_RST = 8'hff;
    localparam logic [NUM_SRC-1:0] DIS_RST_VEC = 14'h3fff;
    localparam logic [NUM_SRC-1:0] PEND_RST_VEC = 14'h0000;

    // Layout of the low byte: unused bit 6, transmit in bit 7
    localparam int LO_UNUSED_BIT = 6;
    localparam int LO_TX_BIT = 7;
    localparam int HI_UNUSED_BIT = 7;

    // Control register fields
    localparam int CTRL_IE_BIT = 0;
    localparam int CTRL_WDM_LSB = 1;
    localparam logic [1:0] WDM_INTERVAL = 2'h0;
    localparam logic [1:0] WDM_MODE1 = 2'h1;
    localparam logic [1:0] WDM_MODE2 = 2'h2;

    // Status register fields
    localparam int STAT_REQ_BIT = 16;
    localparam int STAT_NMI_BIT = 17;
    localparam int STAT_STBY_BIT = 18;

    // Service latency in processor clocks
    localparam logic [4:0] SERVICE_MIN_CYC = 5'h09;
    localparam logic [4:0] SERVICE_MAX_CYC = 5'h13;

    typedef enum logic [2:0] {
        VIC_IDLE = 3'b001,
        VIC_WAIT = 3'b010,
        VIC_REQ = 3'b100
    } vic_state_e;

endpackage

// ---- verification/vic_checker.sv ----
// Port assertions for the interrupt controller
`timescale 1ns/10ps
module vic_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cpu_ack,
    input wire logic service_req,
    input wire logic service_nmi,
    input wire logic [15:0] service_vector,
    input wire logic global_irq_enable,
    input wire logic standby_release
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_bus_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus ack missing");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack too long");
    property p_nmi_vec;
        service_req && service_nmi |-> service_vector == 16'h0004;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("wrong nmi vector");
    property p_ack_ends;
        service_req && cpu_ack |=> !service_req && !global_irq_enable;
    endproperty
    a_ack_ends: assert property (p_ack_ends)
        else $error("ack did not end service");
    property p_hold;
        service_req && !cpu_ack |=> service_req && $stable(service_vector);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request dropped before ack");
    // Standby release must have been high 8 clocks before a maskable service starts
    property p_lat;
        $rose(service_req) && !service_nmi |-> $past(standby_release, 8);
    endproperty
    a_lat: assert property (p_lat)
        else $error("service too early");
    property p_stby;
        service_req |-> standby_release;
    endproperty
    a_stby: assert property (p_stby)
        else $error("no standby release");
    property p_ie_need;
        $rose(service_req) && !service_nmi |-> $past(global_irq_enable);
    endproperty
    a_ie_need: assert property (p_ie_need)
        else $error("service without enable");
    c_nmi: cover property (service_req && service_nmi);
    c_mask: cover property (service_req && cpu_ack && !service_nmi);
    c_wake: cover property ($rose(standby_release));
endmodule
bind vic_ctrl vic_checker u_chk (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .cpu_ack(cpu_ack), .service_req(service_req),
    .service_nmi(service_nmi), .service_vector(service_vector),
    .global_irq_enable(global_irq_enable),
    .standby_release(standby_release));

// ---- verification/vic_cpu_model.sv ----
// Behavioural CPU that takes a vector after a set delay
`timescale 1ns/10ps
module vic_cpu_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic service_req,
    input wire logic [3:0] ack_dly,
    output logic cpu_ack
);
    logic [3:0] wait_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 4'h0;
            cpu_ack <= 1'b0;
        end else if (service_req && !cpu_ack) begin
            // Delays above 9 would break the 19 clock service bound
            cpu_ack <= (wait_ff == ack_dly);
            wait_ff <= wait_ff + 4'h1;
        end else begin
            cpu_ack <= 1'b0;
            wait_ff <= 4'h0;
        end
    end
endmodule

// ---- verification/vic_ctrl_tb.sv ----
// Self-checking testbench for the interrupt controller
`timescale 1ns/10ps
module vic_ctrl_tb;
    import vic_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_ack;
    logic service_req, service_nmi, global_irq_enable, standby_release;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, ack_dly;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] service_vector;
    logic [14:0] src;
    int n_mismatch, cmp_count, lat;
    always #2.5 mclk = ~mclk;
    vic_ctrl dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .watchdog_overflow_irq(src[0]),
        .pin_edge_irq_0(src[1]), .pin_edge_irq_1(src[2]),
        .pin_edge_irq_2(src[3]), .pin_edge_irq_3(src[4]),
        .serial_rx_done_irq(src[5]), .serial_sync_xfer_done_irq(src[6]),
        .serial_tx_done_irq(src[7]), .watch_interval_irq(src[8]),
        .timer16_match_irq(src[9]), .timer8a_match_irq(src[10]),
        .timer8b_match_irq(src[11]), .adc_done_irq(src[12]),
        .watch_timer_irq(src[13]), .key_return_irq(src[14]),
        .cpu_ack(cpu_ack), .service_req(service_req),
        .service_nmi(service_nmi), .service_vector(service_vector),
        .global_irq_enable(global_irq_enable),
        .standby_release(standby_release));
    vic_cpu_model u_cpu (.mclk(mclk), .rst_n(rst_n),
        .service_req(service_req), .ack_dly(ack_dly), .cpu_ack(cpu_ack));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1 && t < 50) begin
            @(posedge mclk);
            t++;
        end
        if (t == 50) n_mismatch++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, {24'h0, e});
    endtask
    task fire(input logic [14:0] m);
        src <= m;
        @(posedge mclk);
        src <= 15'h0;
    endtask
    task take(input logic [15:0] v, input logic nmi);
        int t;
        lat = 0;
        t = 0;
        @(negedge mclk);
        while (service_req !== 1'b1 && lat < 100) begin
            @(negedge mclk);
            lat++;
        end
        chk({16'h0, service_vector}, {16'h0, v});
        chk({31'h0, service_nmi}, {31'h0, nmi});
        while (service_req === 1'b1 && t < 50) begin
            @(negedge mclk);
            t++;
        end
        chk({31'h0, global_irq_enable}, 32'h0);
        @(posedge mclk);
    endtask
    function automatic logic [15:0] vexp(input int k);
        return 16'h4 + 16'(2 * k) + ((k >= 6) ? 16'h2 : 16'h0);
    endfunction
    task print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        src = 15'h0;
        ack_dly = 4'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rchk(ADDR_PEND_LO, 8'h00);
        rchk(ADDR_PEND_HI, 8'h00);
        rchk(ADDR_DIS_LO, 8'hff);
        rchk(ADDR_DIS_HI, 8'hff);
        rchk(8'h30, 8'h00);
        wb(1'b1, ADDR_PEND_LO, 32'hbf);
        rchk(ADDR_PEND_LO, 8'hbf);
        wb(1'b1, ADDR_PEND_LO, 32'h0);
        rchk(ADDR_PEND_LO, 8'h00);
        // Pin 1 fires on the very edge the clearing write lands
        fork
            wb(1'b1, ADDR_PEND_LO, 32'h0);
            begin
                @(posedge mclk);
                fire(15'h4);
            end
        join
        rchk(ADDR_PEND_LO, 8'h04);
        fire(15'h10);
        rchk(ADDR_PEND_LO, 8'h14);
        wb(1'b1, ADDR_PEND_LO, 32'h0);
        fire(15'h4000);
        repeat (20) @(negedge mclk);
        chk({31'h0, service_req, standby_release}, 32'h0);
        @(posedge mclk);
        rchk(ADDR_PEND_HI, 8'h40);
        wb(1'b1, ADDR_DIS_HI, 32'hbf);
        repeat (20) @(negedge mclk);
        chk({31'h0, service_req, standby_release}, 32'h1);
        @(posedge mclk);
        wb(1'b1, ADDR_CTRL, 32'h1);
        take(16'h0020, 1'b0);
        wb(1'b1, ADDR_DIS_LO, 32'h40);
        wb(1'b1, ADDR_DIS_HI, 32'h80);
        wb(1'b1, ADDR_CTRL, 32'h1);
        fire(15'h7fbf);
        for (int k = 0; k < 14; k++) begin
            ack_dly <= 4'(k % 10);
            take(vexp(k), 1'b0);
            wb(1'b1, ADDR_CTRL, 32'h1);
        end
        rchk(ADDR_PEND_LO, 8'h00);
        rchk(ADDR_PEND_HI, 8'h00);
        fire(15'h40);
        take(16'h000e, 1'b0);
        chk({31'h0, lat >= 9 && lat <= 19}, 32'h1);
        wb(1'b1, ADDR_CTRL, 32'h3);
        wb(1'b1, ADDR_PEND_LO, 32'h1);
        rchk(ADDR_PEND_LO, 8'h00);
        fire(15'h3);
        take(16'h0004, 1'b1);
        wb(1'b1, ADDR_CTRL, 32'h3);
        take(16'h0006, 1'b0);
        // Mode 2 overflow raises neither variant
        wb(1'b1, ADDR_CTRL, 32'h5);
        fire(15'h1);
        repeat (20) @(negedge mclk);
        chk({31'h0, service_req, standby_release}, 32'h0);
        @(posedge mclk);
        wb(1'b1, ADDR_CTRL, 32'h0);
        rchk(ADDR_PEND_LO, 8'h00);
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        print_verdict;
    end
endmodule
